// [common/spm_cfg.svh]
// Constants of the serial port pin multiplexer
//
// Contract
// - After reset every serial port pin is a general-purpose input.
// - In general-purpose mode a pin's direction follows its direction bit.
// - Control bit set hands the pin to its serial peripheral; ports C, D, E.
// - Control pin zero: async receive clock; sync transmitter 1 or flag 0.
// - Control pin one: async receive frame sync; sync transmitter 2 or flag 1.
// - Control pin two: shared frame sync in sync, transmit only in async.
// - Frame sync pin drives internal sync as output, accepts external as input.
// - Bit clock pin clocks both directions in sync, transmitter only in async.
// - Receive data pin feeds the sync port receive shift register.
// - Transmit data pin is driven from the transmit shift register.
// - Async receive pin feeds the async port receive shift register.
// - Async transmit pin outputs the async transmit data register.
// - Async clock pin is input or output clock for transmitter and receiver.
// - In stop, pins keep configuration; inputs ignored, outputs tri-stated.
// - Entering wait leaves every serial port pin unchanged.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// Register byte addresses
`define SPM_C_CTRL_ADDR   12'h000
`define SPM_C_DIR_ADDR    12'h004
`define SPM_C_DATA_ADDR   12'h008
`define SPM_D_CTRL_ADDR   12'h00C
`define SPM_D_DIR_ADDR    12'h010
`define SPM_D_DATA_ADDR   12'h014
`define SPM_E_CTRL_ADDR   12'h018
`define SPM_E_DIR_ADDR    12'h01C
`define SPM_E_DATA_ADDR   12'h020
`define SPM_PIN_ADDR      12'h024
`define SPM_MODE_ADDR     12'h028

// Field positions in the mode register
`define SPM_MODE_C_ASYNC  0
`define SPM_MODE_D_ASYNC  1
`define SPM_MODE_STOP     2

// Reset values: all pins general-purpose inputs
`define SPM_CTRL_RST      6'h00
`define SPM_DIR_RST       6'h00
`define SPM_DATA_RST      6'h00
`define SPM_MODE_RST      3'h0

// Timing: least external bit clock period in system phases
`define SPM_MIN_CLK_PHASES 6

`endif

// [common/spm_pkg.sv]
// Types of the serial port pin multiplexer
package spm_pkg;
	typedef enum logic [1:0] {
		SPM_IDLE_type_S = 2'b01,
		SPM_DATA_type_S = 2'b10
	} spm_bus_state_type;
endpackage

// [src/spm_pin_sync.sv]
// Two-flip-flop synchroniser for a bank of pin inputs
module spm_pin_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// Next values of the two stages
	always_comb
	begin
		meta_d = din;
		sync_d = meta_q;
	end

	// Register both stages
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule

// [src/spm_pin_mux.sv]
// Serial port pin multiplexer with AHB-Lite register slave
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`include "spm_cfg.svh"
module spm_pin_mux
	import spm_pkg::*;
#(
	parameter int NPIN = 6,
	parameter int NPIN_E = 3
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	// AHB-Lite slave
	input  wire logic              HSEL,
	input  wire logic [11:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// Processor power state
	input  wire logic              STOP_MODE,
	input  wire logic              WAIT_MODE,
	// Pins of ports C, D, E
	input  wire logic [NPIN-1:0]   PORTC_IN,
	output logic      [NPIN-1:0]   PORTC_OUT,
	output logic      [NPIN-1:0]   PORTC_OE,
	input  wire logic [NPIN-1:0]   PORTD_IN,
	output logic      [NPIN-1:0]   PORTD_OUT,
	output logic      [NPIN-1:0]   PORTD_OE,
	input  wire logic [NPIN_E-1:0] PORTE_IN,
	output logic      [NPIN_E-1:0] PORTE_OUT,
	output logic      [NPIN_E-1:0] PORTE_OE,
	// Sync serial port 0 peripheral side
	input  wire logic              P0_TX1_OUT,
	input  wire logic              P0_FS_OUT,
	input  wire logic              P0_FS_OE,
	input  wire logic              P0_CTRL_ONE_OUT,
	input  wire logic              P0_CTRL_ZERO_OE,
	input  wire logic              P0_CTRL_ONE_OE,
	input  wire logic              P0_CLK_OUT,
	input  wire logic              P0_CLK_OE,
	input  wire logic              P0_TX_DATA,
	input  wire logic              P0_TX_ACTIVE,
	output logic                   P0_RX_CLK_IN,
	output logic                   P0_RX_FS_IN,
	output logic                   P0_TX_FS_IN,
	output logic                   P0_TX_CLK_IN,
	output logic                   P0_RX_DATA_IN,
	// Sync serial port 1 peripheral side
	input  wire logic              P1_TX1_OUT,
	input  wire logic              P1_FS_OUT,
	input  wire logic              P1_FS_OE,
	input  wire logic              P1_CTRL_ONE_OUT,
	input  wire logic              P1_CTRL_ZERO_OE,
	input  wire logic              P1_CTRL_ONE_OE,
	input  wire logic              P1_CLK_OUT,
	input  wire logic              P1_CLK_OE,
	input  wire logic              P1_TX_DATA,
	input  wire logic              P1_TX_ACTIVE,
	output logic                   P1_RX_CLK_IN,
	output logic                   P1_RX_FS_IN,
	output logic                   P1_TX_FS_IN,
	output logic                   P1_TX_CLK_IN,
	output logic                   P1_RX_DATA_IN,
	// Async serial port peripheral side
	input  wire logic              A_TX_DATA,
	input  wire logic              A_CLK_OUT,
	input  wire logic              A_CLK_OE,
	output logic                   A_RX_DATA_IN,
	output logic                   A_CLK_IN
);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// Register state
	logic [NPIN-1:0]   c_ctrl_q, c_ctrl_d, c_dir_q, c_dir_d;
	logic [NPIN-1:0]   c_dat_q, c_dat_d;
	logic [NPIN-1:0]   d_ctrl_q, d_ctrl_d, d_dir_q, d_dir_d;
	logic [NPIN-1:0]   d_dat_q, d_dat_d;
	logic [NPIN_E-1:0] e_ctrl_q, e_ctrl_d, e_dir_q, e_dir_d;
	logic [NPIN_E-1:0] e_dat_q, e_dat_d;
	logic [2:0]        mode_q, mode_d;
	// Bus state
	spm_bus_state_type state_q, state_d;
	logic [11:0]       addr_q, addr_d;
	logic              wr_q, wr_d;
	logic [31:0]       rdata_q, rdata_d;
	// Pin output and peripheral input state
	logic [NPIN-1:0]   c_out_q, c_out_d, c_oe_q, c_oe_d;
	logic [NPIN-1:0]   d_out_q, d_out_d, d_oe_q, d_oe_d;
	logic [NPIN_E-1:0] e_out_q, e_out_d, e_oe_q, e_oe_d;
	logic [4:0]        p0_in_q, p0_in_d, p1_in_q, p1_in_d;
	logic [1:0]        a_in_q, a_in_d;
	// Synchronised pin levels
	logic [NPIN-1:0]   c_sync, d_sync;
	logic [NPIN_E-1:0] e_sync;
	logic [NPIN-1:0]   c_lat_q, c_lat_d, d_lat_q, d_lat_d;
	logic [NPIN_E-1:0] e_lat_q, e_lat_d;

	// All pin inputs pass two flops before use
	spm_pin_sync #(.WIDTH(NPIN)) u_sync_c (
		.clk  (SYS_CLK),
		.rst  (RST),
		.din  (PORTC_IN),
		.dout (c_sync)
	);
	spm_pin_sync #(.WIDTH(NPIN)) u_sync_d (
		.clk  (SYS_CLK),
		.rst  (RST),
		.din  (PORTD_IN),
		.dout (d_sync)
	);
	spm_pin_sync #(.WIDTH(NPIN_E)) u_sync_e (
		.clk  (SYS_CLK),
		.rst  (RST),
		.din  (PORTE_IN),
		.dout (e_sync)
	);

	// One sync serial port's pin outputs and enables
	function automatic logic [2*NPIN-1:0] sync_port_pins(
		input logic [NPIN-1:0] ctrl,
		input logic [NPIN-1:0] dir,
		input logic [NPIN-1:0] dat,
		input logic            async_md,
		input logic            tx1,
		input logic            c1_out,
		input logic            c0_oe,
		input logic            c1_oe,
		input logic            fs,
		input logic            fs_oe,
		input logic            ck,
		input logic            ck_oe,
		input logic            txd,
		input logic            tx_act
	);
		logic [NPIN-1:0] per_out;
		logic [NPIN-1:0] per_oe;
		per_out = '0;
		per_oe = '0;
		// Pin 0: async rx clock, sync tx1 or flag 0
		per_out[0] = tx1;
		per_oe[0] = c0_oe;
		// Pin 1: async rx frame sync, sync tx2 or flag 1
		per_out[1] = c1_out;
		per_oe[1] = c1_oe;
		// Pin 2: internal frame sync when output
		per_out[2] = fs;
		per_oe[2] = fs_oe;
		// Pin 3: bit clock in or out
		per_out[3] = ck;
		per_oe[3] = ck_oe;
		// Pin 4 receive data is input only
		// Pin 5 driven only while transmitting
		per_out[5] = txd;
		per_oe[5] = tx_act;
		// Bit n of control and direction governs pin n
		return {(ctrl & per_out) | (~ctrl & dat),
			(ctrl & per_oe) | (~ctrl & dir)};
	endfunction

	// AHB-Lite address and data phase
	always_comb
	begin
		state_d = state_q;
		addr_d = addr_q;
		wr_d = wr_q;
		rdata_d = rdata_q;
		c_ctrl_d = c_ctrl_q;
		c_dir_d = c_dir_q;
		c_dat_d = c_dat_q;
		d_ctrl_d = d_ctrl_q;
		d_dir_d = d_dir_q;
		d_dat_d = d_dat_q;
		e_ctrl_d = e_ctrl_q;
		e_dir_d = e_dir_q;
		e_dat_d = e_dat_q;
		mode_d = mode_q;
		// Finish a write in its data phase
		if (state_q == SPM_DATA_type_S && wr_q)
		begin
			if (addr_q == `SPM_C_CTRL_ADDR)
				c_ctrl_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_C_DIR_ADDR)
				c_dir_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_C_DATA_ADDR)
				c_dat_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_D_CTRL_ADDR)
				d_ctrl_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_D_DIR_ADDR)
				d_dir_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_D_DATA_ADDR)
				d_dat_d = HWDATA[NPIN-1:0];
			else if (addr_q == `SPM_E_CTRL_ADDR)
				e_ctrl_d = HWDATA[NPIN_E-1:0];
			else if (addr_q == `SPM_E_DIR_ADDR)
				e_dir_d = HWDATA[NPIN_E-1:0];
			else if (addr_q == `SPM_E_DATA_ADDR)
				e_dat_d = HWDATA[NPIN_E-1:0];
			else if (addr_q == `SPM_MODE_ADDR)
				mode_d = HWDATA[2:0];
		end
		state_d = SPM_IDLE_type_S;
		// Take a new address phase
		if (HSEL && HREADY
			&& (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ))
		begin
			state_d = SPM_DATA_type_S;
			addr_d = {HADDR[11:2], 2'b00};
			wr_d = HWRITE;
			rdata_d = 32'h0000_0000;
			if (HADDR[11:2] == `SPM_C_CTRL_ADDR >> 2)
				rdata_d[NPIN-1:0] = c_ctrl_d;
			else if (HADDR[11:2] == `SPM_C_DIR_ADDR >> 2)
				rdata_d[NPIN-1:0] = c_dir_d;
			else if (HADDR[11:2] == `SPM_C_DATA_ADDR >> 2)
				rdata_d[NPIN-1:0] = c_dat_d;
			else if (HADDR[11:2] == `SPM_D_CTRL_ADDR >> 2)
				rdata_d[NPIN-1:0] = d_ctrl_d;
			else if (HADDR[11:2] == `SPM_D_DIR_ADDR >> 2)
				rdata_d[NPIN-1:0] = d_dir_d;
			else if (HADDR[11:2] == `SPM_D_DATA_ADDR >> 2)
				rdata_d[NPIN-1:0] = d_dat_d;
			else if (HADDR[11:2] == `SPM_E_CTRL_ADDR >> 2)
				rdata_d[NPIN_E-1:0] = e_ctrl_d;
			else if (HADDR[11:2] == `SPM_E_DIR_ADDR >> 2)
				rdata_d[NPIN_E-1:0] = e_dir_d;
			else if (HADDR[11:2] == `SPM_E_DATA_ADDR >> 2)
				rdata_d[NPIN_E-1:0] = e_dat_d;
			else if (HADDR[11:2] == `SPM_PIN_ADDR >> 2)
				rdata_d[2*NPIN+NPIN_E-1:0] = {e_lat_q, d_lat_q, c_lat_q};
			else if (HADDR[11:2] == `SPM_MODE_ADDR >> 2)
				rdata_d[2:0] = mode_d;
		end
	end

	// Pin multiplexing and peripheral inputs
	always_comb
	begin
		logic stop;
		stop = mode_q[`SPM_MODE_STOP] | STOP_MODE;
		{c_out_d, c_oe_d} = sync_port_pins(c_ctrl_q, c_dir_q, c_dat_q,
			mode_q[`SPM_MODE_C_ASYNC], P0_TX1_OUT, P0_CTRL_ONE_OUT,
			P0_CTRL_ZERO_OE, P0_CTRL_ONE_OE, P0_FS_OUT, P0_FS_OE,
			P0_CLK_OUT, P0_CLK_OE, P0_TX_DATA, P0_TX_ACTIVE);
		{d_out_d, d_oe_d} = sync_port_pins(d_ctrl_q, d_dir_q, d_dat_q,
			mode_q[`SPM_MODE_D_ASYNC], P1_TX1_OUT, P1_CTRL_ONE_OUT,
			P1_CTRL_ZERO_OE, P1_CTRL_ONE_OE, P1_FS_OUT, P1_FS_OE,
			P1_CLK_OUT, P1_CLK_OE, P1_TX_DATA, P1_TX_ACTIVE);
		// Async port: pin 0 in, pin 1 out, pin 2 clock
		e_out_d = (e_ctrl_q & {A_CLK_OUT, A_TX_DATA, 1'b0})
			| (~e_ctrl_q & e_dat_q);
		e_oe_d = (e_ctrl_q & {A_CLK_OE, 1'b1, 1'b0})
			| (~e_ctrl_q & e_dir_q);
		// Input sampling frozen in stop, not in wait
		c_lat_d = stop ? c_lat_q : c_sync;
		d_lat_d = stop ? d_lat_q : d_sync;
		e_lat_d = stop ? e_lat_q : e_sync;
		// Stop: outputs tri-stated, config kept
		if (stop)
		begin
			c_oe_d = '0;
			d_oe_d = '0;
			e_oe_d = '0;
		end
		// Clock and frame sync routing by mode
		p0_in_d = {c_lat_d[4], c_lat_d[3],
			c_lat_d[2],
			mode_q[`SPM_MODE_C_ASYNC] ? c_lat_d[1] : c_lat_d[2],
			mode_q[`SPM_MODE_C_ASYNC] ? c_lat_d[0] : c_lat_d[3]};
		p1_in_d = {d_lat_d[4], d_lat_d[3],
			d_lat_d[2],
			mode_q[`SPM_MODE_D_ASYNC] ? d_lat_d[1] : d_lat_d[2],
			mode_q[`SPM_MODE_D_ASYNC] ? d_lat_d[0] : d_lat_d[3]};
		p0_in_d = p0_in_d & {5{c_ctrl_q[4] | ~c_ctrl_q[4]}};
		a_in_d = {e_lat_d[2], e_lat_d[0]};
		// Peripheral inputs gated by ownership; rx clock and frame sync pass if either of their two pins is owned
		p0_in_d = p0_in_d & {c_ctrl_q[4], c_ctrl_q[3], c_ctrl_q[2],
			c_ctrl_q[1] | c_ctrl_q[2], c_ctrl_q[0] | c_ctrl_q[3]};
		p1_in_d = p1_in_d & {d_ctrl_q[4], d_ctrl_q[3], d_ctrl_q[2],
			d_ctrl_q[1] | d_ctrl_q[2], d_ctrl_q[0] | d_ctrl_q[3]};
		a_in_d = a_in_d & {e_ctrl_q[2], e_ctrl_q[0]};
	end

	// Register all state; reset makes every pin an input
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			state_q <= SPM_IDLE_type_S;
			addr_q <= 12'h000;
			wr_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			c_ctrl_q <= `SPM_CTRL_RST;
			c_dir_q <= `SPM_DIR_RST;
			c_dat_q <= `SPM_DATA_RST;
			d_ctrl_q <= `SPM_CTRL_RST;
			d_dir_q <= `SPM_DIR_RST;
			d_dat_q <= `SPM_DATA_RST;
			e_ctrl_q <= NPIN_E'(`SPM_CTRL_RST);
			e_dir_q <= NPIN_E'(`SPM_DIR_RST);
			e_dat_q <= NPIN_E'(`SPM_DATA_RST);
			mode_q <= `SPM_MODE_RST;
			c_out_q <= '0;
			c_oe_q <= '0;
			d_out_q <= '0;
			d_oe_q <= '0;
			e_out_q <= '0;
			e_oe_q <= '0;
			c_lat_q <= '0;
			d_lat_q <= '0;
			e_lat_q <= '0;
			p0_in_q <= '0;
			p1_in_q <= '0;
			a_in_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			rdata_q <= rdata_d;
			c_ctrl_q <= c_ctrl_d;
			c_dir_q <= c_dir_d;
			c_dat_q <= c_dat_d;
			d_ctrl_q <= d_ctrl_d;
			d_dir_q <= d_dir_d;
			d_dat_q <= d_dat_d;
			e_ctrl_q <= e_ctrl_d;
			e_dir_q <= e_dir_d;
			e_dat_q <= e_dat_d;
			mode_q <= mode_d;
			c_out_q <= c_out_d;
			c_oe_q <= c_oe_d;
			d_out_q <= d_out_d;
			d_oe_q <= d_oe_d;
			e_out_q <= e_out_d;
			e_oe_q <= e_oe_d;
			c_lat_q <= c_lat_d;
			d_lat_q <= d_lat_d;
			e_lat_q <= e_lat_d;
			p0_in_q <= p0_in_d;
			p1_in_q <= p1_in_d;
			a_in_q <= a_in_d;
		end
	end

	// Outputs straight from flops; HREADYOUT and HRESP tied to constants
	assign HRDATA = rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign PORTC_OUT = c_out_q;
	assign PORTC_OE = c_oe_q;
	assign PORTD_OUT = d_out_q;
	assign PORTD_OE = d_oe_q;
	assign PORTE_OUT = e_out_q;
	assign PORTE_OE = e_oe_q;
	assign {P0_RX_DATA_IN, P0_TX_CLK_IN, P0_TX_FS_IN, P0_RX_FS_IN,
		P0_RX_CLK_IN} = p0_in_q;
	assign {P1_RX_DATA_IN, P1_TX_CLK_IN, P1_TX_FS_IN, P1_RX_FS_IN,
		P1_RX_CLK_IN} = p1_in_q;
	assign {A_CLK_IN, A_RX_DATA_IN} = a_in_q;
endmodule

// [testbench/spm_pin_mux_assertions.sv]
// Port-level checks of the serial port pin multiplexer
module spm_pin_mux_assertions #(
	parameter int NPIN   = 6,
	parameter int NPIN_E = 3
) (
	input wire logic              SYS_CLK,
	input wire logic              RST,
	input wire logic              HSEL,
	input wire logic [1:0]        HTRANS,
	input wire logic              HREADY,
	input wire logic [31:0]       HRDATA,
	input wire logic              HREADYOUT,
	input wire logic              HRESP,
	input wire logic              STOP_MODE,
	input wire logic              WAIT_MODE,
	input wire logic [NPIN-1:0]   PORTC_IN,
	input wire logic [NPIN-1:0]   PORTC_OE,
	input wire logic [NPIN-1:0]   PORTD_OE,
	input wire logic [NPIN_E-1:0] PORTE_IN,
	input wire logic [NPIN_E-1:0] PORTE_OE,
	input wire logic              P0_RX_DATA_IN,
	input wire logic              A_RX_DATA_IN,
	input wire logic              A_CLK_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	// All pin enables seen as one bank
	wire [2*NPIN+NPIN_E-1:0] all_oe = {PORTE_OE, PORTD_OE, PORTC_OE};

	// No bus transfer for three cycles
	sequence quiet_s;
		!HSEL [*3];
	endsequence
	// Stop input held long enough to reach the pins
	sequence stop_held_s;
		STOP_MODE [*3];
	endsequence

	// Zero-wait, always-OKAY slave
	ready_hi_a: assert property (HREADYOUT)
		else $error("Ready output went low");
	okay_resp_a: assert property (!HRESP)
		else $error("Error response seen");
	// Reset leaves every pin an undriven input
	reset_idle_a: assert property (disable iff (1'b0) RST |=> all_oe == '0)
		else $error("Pin driven after reset");
	reset_feed_a: assert property (disable iff (1'b0)
		RST |=> !P0_RX_DATA_IN && !A_RX_DATA_IN)
		else $error("Peripheral input live after reset");
	// Stop tri-states every output
	stop_tri_a: assert property (stop_held_s |-> all_oe == '0)
		else $error("Pin driven in stop");
	// Entering wait changes no port E pin enable
	wait_hold_a: assert property (quiet_s ##0 ($rose(WAIT_MODE) &&
		!STOP_MODE && $stable(STOP_MODE) && $stable(A_CLK_OE))
		|=> $stable(PORTE_OE))
		else $error("Wait changed a pin");
	// Read data stands until the next accepted address phase
	rd_stand_a: assert property (!(HSEL && HREADY && HTRANS[1])
		|=> $stable(HRDATA))
		else $error("Read data changed without transfer");
	// Receive pins reach their shift registers three edges later
	rx_path_a: assert property (P0_RX_DATA_IN && !STOP_MODE
		|-> $past(PORTC_IN[4], 3))
		else $error("Sync receive data without pin level");
	async_rx_a: assert property (A_RX_DATA_IN && !STOP_MODE
		|-> $past(PORTE_IN[0], 3))
		else $error("Async receive data without pin level");
endmodule

// [testbench/spm_far_model.sv]
// Far-side serial device on one pin port
module spm_far_model #(
	parameter int W   = 6,
	parameter int CKI = 3
) (
	input  wire logic [W-1:0] dut_out,
	input  wire logic [W-1:0] dut_oe,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_oe,
	input  wire logic         clk_run,
	output logic      [W-1:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic         ck_q   = 1'b0;
	logic [W-1:0] last_q = '0;
	logic [W-1:0] drv;

	// Bit clock of 64 ns, odd phase, still between frames
	initial
	begin
		#5;
		forever
		begin
			#32;
			if (clk_run)
				ck_q = ~ck_q;
		end
	end

	// Own levels, clock pin from the bit clock while running
	always_comb
	begin
		drv = ext_val;
		drv[CKI] = clk_run ? ck_q : ext_val[CKI];
	end

	// Wire level: device first, then far side, else inverse of last
	always_comb
		for (int i = 0; i < W; i++)
			pin[i] = dut_oe[i] ? dut_out[i] : (ext_oe[i] ? drv[i] : ~last_q[i]);

	// Last driven level of each line
	always @(dut_out or dut_oe or drv or ext_oe)
		for (int i = 0; i < W; i++)
			if (dut_oe[i] || ext_oe[i])
				last_q[i] <= dut_oe[i] ? dut_out[i] : drv[i];
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the serial port pin multiplexer
`include "spm_cfg.svh"
`define CHK(g, e) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [14:0] DM = 15'h55A9;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        hsel   = 1'b0;
	logic        hwrite = 1'b0;
	logic        stop   = 1'b0;
	logic        wt     = 1'b0;
	logic        run    = 1'b0;
	logic        lv     = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize  = 3'h0;
	logic [14:0] eo     = 15'h7FFF;
	logic [11:0] haddr  = 12'h000;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rv;
	logic [14:0] ev     = 15'h0000;
	logic [9:0]  p0     = 10'h000;
	logic [9:0]  p1     = 10'h000;
	logic [2:0]  a      = 3'h0;
	wire  [31:0] hrdata;
	wire         hready;
	wire  [14:0] pin;
	wire  [14:0] dout;
	wire  [14:0] doe;
	wire  [4:0]  q0;
	wire  [4:0]  q1;
	wire  [1:0]  qa;
	int          tg;
	int          mismatches = 0;
	int          cmp_count  = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	spm_pin_mux spm_pin_mux_i (
		.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
		.STOP_MODE(stop), .WAIT_MODE(wt), .PORTC_IN(pin[5:0]),
		.PORTC_OUT(dout[5:0]), .PORTC_OE(doe[5:0]), .PORTD_IN(pin[11:6]),
		.PORTD_OUT(dout[11:6]), .PORTD_OE(doe[11:6]),
		.PORTE_IN(pin[14:12]), .PORTE_OUT(dout[14:12]),
		.PORTE_OE(doe[14:12]), .P0_TX1_OUT(p0[0]), .P0_FS_OUT(p0[1]),
		.P0_FS_OE(p0[2]), .P0_CTRL_ONE_OUT(p0[3]), .P0_CTRL_ZERO_OE(p0[4]),
		.P0_CTRL_ONE_OE(p0[5]), .P0_CLK_OUT(p0[6]), .P0_CLK_OE(p0[7]),
		.P0_TX_DATA(p0[8]), .P0_TX_ACTIVE(p0[9]), .P0_RX_CLK_IN(q0[4]),
		.P0_RX_FS_IN(q0[3]), .P0_TX_FS_IN(q0[2]), .P0_TX_CLK_IN(q0[1]),
		.P0_RX_DATA_IN(q0[0]), .P1_TX1_OUT(p1[0]), .P1_FS_OUT(p1[1]),
		.P1_FS_OE(p1[2]), .P1_CTRL_ONE_OUT(p1[3]), .P1_CTRL_ZERO_OE(p1[4]),
		.P1_CTRL_ONE_OE(p1[5]), .P1_CLK_OUT(p1[6]), .P1_CLK_OE(p1[7]),
		.P1_TX_DATA(p1[8]), .P1_TX_ACTIVE(p1[9]), .P1_RX_CLK_IN(q1[4]),
		.P1_RX_FS_IN(q1[3]), .P1_TX_FS_IN(q1[2]), .P1_TX_CLK_IN(q1[1]),
		.P1_RX_DATA_IN(q1[0]), .A_TX_DATA(a[0]), .A_CLK_OUT(a[1]),
		.A_CLK_OE(a[2]), .A_RX_DATA_IN(qa[1]), .A_CLK_IN(qa[0]));

	// Far-side devices on ports C, D and E
	spm_far_model far_c_i (.dut_out(dout[5:0]),
		.dut_oe(doe[5:0]), .ext_val(ev[5:0]), .ext_oe(eo[5:0]),
		.clk_run(run), .pin(pin[5:0]));
	spm_far_model far_d_i (.dut_out(dout[11:6]),
		.dut_oe(doe[11:6]), .ext_val(ev[11:6]), .ext_oe(eo[11:6]),
		.clk_run(run), .pin(pin[11:6]));
	spm_far_model #(.W(3), .CKI(2)) far_e_i (.dut_out(dout[14:12]),
		.dut_oe(doe[14:12]), .ext_val(ev[14:12]), .ext_oe(eo[14:12]),
		.clk_run(run), .pin(pin[14:12]));

	// Single AHB-Lite write, address phase then data phase
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'b10;
		hsize <= 3'h2;
		hwrite <= 1'b1;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
	endtask

	// Single AHB-Lite read, data taken at the data phase edge
	task automatic rd(input logic [11:0] ad, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'b10;
		hsize <= 3'h2;
		hwrite <= 1'b0;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		do @(posedge clk); while (hready !== 1'b1);
		d = hrdata;
	endtask

	task automatic nap(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic conclude();
		$display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(doe, 15'h0000)
		for (int i = 0; i < 12; i++)
		begin
			rd(12'(i * 4), rv);
			`CHK(rv, 32'h0)
		end
		// General-purpose direction per pin, pins read back
		ev <= 15'h2492;
		for (int p = 0; p < 3; p++)
		begin
			wr(12'(p * 12 + 4), 32'((DM >> (p * 6)) & 15'h3F));
			wr(12'(p * 12 + 8), 32'h3F);
		end
		nap(2);
		`CHK(doe, DM)
		`CHK(dout & doe, DM)
		rd(`SPM_D_DIR_ADDR, rv);
		`CHK(rv, 32'h16)
		rd(`SPM_PIN_ADDR, rv);
		`CHK(rv[14:0], DM | (~DM & 15'h2492))
		for (int p = 0; p < 3; p++)
			wr(12'(p * 12 + 4), 32'h0);
		// Sync port C drives; receive pin never driven
		wr(`SPM_C_CTRL_ADDR, 32'h3F);
		p0 <= 10'h3FF;
		nap(3);
		`CHK(doe[5:0], 6'h2F)
		`CHK(dout[3:0], 4'hF)
		`CHK(dout[5], 1'b1)
		p0 <= 10'h1FF;
		nap(3);
		`CHK(doe[5], 1'b0)
		// Sync port C listens to clock, frame sync and data
		p0 <= 10'h000;
		ev[3:0] <= 4'h4;
		run <= 1'b1;
		nap(8);
		`CHK(q0[3:2], 2'b11)
		`CHK(q0[0], 1'b1)
		tg = 0;
		for (int i = 0; i < 32; i++)
		begin
			@(posedge clk);
			`CHK(q0[4], q0[1])
			if (q0[1] !== lv)
				tg++;
			lv = q0[1];
		end
		`CHK(tg > 4, 1'b1)
		// Async mode: receive clock and sync move to pins 0 and 1
		run <= 1'b0;
		wr(`SPM_MODE_ADDR, 32'h1);
		ev[3:0] <= 4'h5;
		nap(8);
		`CHK(q0, 5'h15)
		ev[3:0] <= 4'hA;
		nap(8);
		`CHK(q0, 5'h0B)
		// Second sync port on port D
		wr(`SPM_D_CTRL_ADDR, 32'h3F);
		p1 <= 10'h011;
		ev[9:8] <= 2'b11;
		nap(6);
		`CHK({doe[6], dout[6]}, 2'b11)
		`CHK(q1, 5'h1F)
		// Async port: transmit, receive, clock both ways
		wr(`SPM_E_CTRL_ADDR, 32'h7);
		a <= 3'h7;
		ev[14:12] <= 3'h1;
		nap(6);
		`CHK(doe[14:12], 3'h6)
		`CHK(dout[14:13], 2'b11)
		`CHK(qa[1], 1'b1)
		a <= 3'h1;
		ev[14:12] <= 3'h5;
		nap(6);
		`CHK(qa, 2'b11)
		`CHK(doe[14:12], 3'h2)
		// Wait leaves pins alone
		nap(4);
		wt <= 1'b1;
		nap(3);
		`CHK(doe, 15'h2040)
		wt <= 1'b0;
		// Stop tri-states, freezes inputs, keeps configuration
		stop <= 1'b1;
		nap(3);
		`CHK(doe, 15'h0000)
		ev[12] <= 1'b0;
		nap(6);
		`CHK(qa[1], 1'b1)
		ev[12] <= 1'b1;
		nap(6);
		stop <= 1'b0;
		nap(3);
		`CHK(doe, 15'h2040)
		wr(`SPM_MODE_ADDR, 32'h5);
		nap(2);
		`CHK(doe, 15'h0000)
		wr(`SPM_MODE_ADDR, 32'h1);
		nap(2);
		`CHK(doe, 15'h2040)
		conclude();
	end

	// Watchdog: the tests need well under 1000 cycles
	initial
	begin
		#40000;
		mismatches++;
		conclude();
	end
endmodule

bind spm_pin_mux spm_pin_mux_assertions #(.NPIN(NPIN), .NPIN_E(NPIN_E))
	spm_pin_mux_assertions_i (.SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL),
	.HTRANS(HTRANS), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .STOP_MODE(STOP_MODE),
	.WAIT_MODE(WAIT_MODE), .PORTC_IN(PORTC_IN), .PORTC_OE(PORTC_OE),
	.PORTD_OE(PORTD_OE), .PORTE_IN(PORTE_IN), .PORTE_OE(PORTE_OE),
	.P0_RX_DATA_IN(P0_RX_DATA_IN), .A_RX_DATA_IN(A_RX_DATA_IN),
	.A_CLK_OE(A_CLK_OE));
